// ===== tip_pkg.sv
// Constants shared by the timer interrupt, prescaler and flag slice.
// Assumes an 8-bit APB byte address space with one 32-bit word per register.
package tip_pkg;

    // APB address width and register byte offsets.
    localparam int         APB_ADDR_W      = 8;
    localparam logic [7:0] SYS_CTRL_OFFS   = 8'h00;
    localparam logic [7:0] CHAN_IEN_OFFS   = 8'h04;
    localparam logic [7:0] CNT_CTRL_OFFS   = 8'h08;
    localparam logic [7:0] CHAN_FLAG_OFFS  = 8'h0c;
    localparam logic [7:0] OVF_FLAG_OFFS   = 8'h10;

    // Channel group: four channels held in bits 7:4.
    localparam int CHAN_COUNT = 4;
    localparam int CHAN_LSB   = 4;

    // Field positions.
    localparam int FAST_CLEAR_BIT    = 4;
    localparam int OVF_IRQ_EN_BIT    = 7;
    localparam int CMP7_CLEAR_BIT    = 3;
    localparam int DIV_SEL_LSB       = 0;
    localparam int DIV_SEL_W         = 3;
    localparam int OVF_FLAG_BIT      = 7;

    // Writable bits of each register; everything else reads as zero.
    localparam logic [7:0] SYS_CTRL_MASK  = 8'h10;
    localparam logic [7:0] CHAN_IEN_MASK  = 8'hf0;
    localparam logic [7:0] CNT_CTRL_MASK  = 8'h8f;
    localparam logic [7:0] CHAN_FLAG_MASK = 8'hf0;
    localparam logic [7:0] OVF_FLAG_MASK  = 8'h80;

    // Values after reset.
    localparam logic [7:0] SYS_CTRL_RST  = 8'h00;
    localparam logic [7:0] CHAN_IEN_RST  = 8'h00;
    localparam logic [7:0] CNT_CTRL_RST  = 8'h00;
    localparam logic [7:0] CHAN_FLAG_RST = 8'h00;
    localparam logic [7:0] OVF_FLAG_RST  = 8'h00;
    localparam logic [2:0] DIV_SEL_RST   = 3'h0;
    localparam logic [6:0] PRESC_CNT_RST = 7'h00;

endpackage

// ===== tip_presc_if.sv
// Link between the control slice and its prescaler.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
interface tip_presc_if #(
    parameter int SEL_W = 3
);
    logic [SEL_W-1:0] divSel;     // Requested divider select.
    logic [SEL_W-1:0] activeSel;  // Divider select now in use.
    logic             tick;       // One-cycle timer clock enable.

    // Control side requests a ratio and sees the ticks.
    modport ctrl (
        output divSel,
        input  activeSel,
        input  tick
    );

    // Prescaler side takes the request and makes the ticks.
    modport presc (
        input  divSel,
        output activeSel,
        output tick
    );
endinterface

// ===== tip_prescaler.sv
// Bus-clock prescaler: divides by two to the power of the active select.
// Assumes the requested select may change at any cycle.
`timescale 1ns/1ps
module tip_prescaler
    import tip_pkg::*;
#(
    parameter int SEL_W = DIV_SEL_W
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Link to the control slice.
    tip_presc_if.presc pif
);
    localparam int CNT_W = (1 << SEL_W) - 1;

    logic [CNT_W-1:0] cnt_reg;
    logic [SEL_W-1:0] activeSel_reg;
    logic [CNT_W-1:0] lastCount;
    logic             wrap;

    // Terminal count is the select's number of low ones, so ratio 1 wraps every cycle.
    assign lastCount = ~({CNT_W{1'b1}} << activeSel_reg);
    assign wrap      = (cnt_reg == lastCount);

    // Count stages run from zero to the terminal count and return to zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= PRESC_CNT_RST[CNT_W-1:0];
        end else if (wrap) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // A new ratio is adopted only as the stages return to zero, so no
    // prescale cycle is ever cut short or stretched midway.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            activeSel_reg <= DIV_SEL_RST[SEL_W-1:0];
        end else if (wrap) begin
            activeSel_reg <= pif.divSel;
        end
    end

    // Outputs toward the control slice.
    assign pif.tick      = wrap;
    assign pif.activeSel = activeSel_reg;

endmodule

// ===== tip_timer_ctrl.sv
// Control and status slice of a 16-bit timer: interrupt enables, prescaler,
// counter clear on channel-7 compare, channel and overflow flags.
// Assumes the counter, compare and capture engines sit outside, share the
// bus clock, and report through single-cycle strobes sampled here.
//
// Contract
// - Channel enables bits 7:4 gate matching flags.
// - Overflow enable bit 7 gates overflow request.
// - Clear bit 3 resets counter on compare 7.
// - Compare value zero with clear holds counter zero.
// - Compare-driven reset from maximum never sets overflow.
// - Divider select gives bus clock over two-power.
// - New ratio applies only when stages are zero.
// - Channel event sets its flag.
// - Writing one clears flag; zero leaves it.
// - Fast clear: capture read or compare write clears.
// - Fast clear: counter access clears overflow flag.
// - Counter rollover to zero sets overflow flag.
// - Overflow flag write with bit 7 clears it.
// - Fast clear enable is system control bit 4.
`timescale 1ns/1ps
module tip_timer_ctrl
    import tip_pkg::*;
(
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Strobes from the channel engines, one bit per channel 7:4.
    input  wire logic [CHAN_COUNT-1:0] chanEventStrobe,
    input  wire logic [CHAN_COUNT-1:0] captureReadStrobe,
    input  wire logic [CHAN_COUNT-1:0] compareWriteStrobe,
    // Status and strobes from the counter datapath.
    input  wire logic                  counterAccessStrobe,
    input  wire logic                  counterAtMax,
    input  wire logic                  compare7Match,
    input  wire logic                  compare7IsZero,
    // Controls toward the counter datapath.
    output logic                       prescaleTick,
    output logic                       counterClear,
    output logic                       fastClearActive,
    // Interrupt requests.
    output logic [CHAN_COUNT-1:0]      chanIrqReq,
    output logic                       ovfIrqReq,
    output logic                       irq
);

    // Register state.
    logic                  fastClearEn_reg;
    logic [CHAN_COUNT-1:0] chanIrqEn_reg;
    logic                  ovfIrqEn_reg;
    logic                  cmp7ClearEn_reg;
    logic [DIV_SEL_W-1:0]  divSel_reg;
    logic [CHAN_COUNT-1:0] chanFlag_reg;
    logic                  ovfFlag_reg;
    logic [31:0]           prdata_reg;

    // Next values of the flags.
    logic [CHAN_COUNT-1:0] chanFlag_next;
    logic                  ovfFlag_next;

    // Bus decode.
    logic                  setupPhase;
    logic                  accessPhase;
    logic                  wrStrobe;
    logic                  hitSysCtrl;
    logic                  hitChanIen;
    logic                  hitCntCtrl;
    logic                  hitChanFlag;
    logic                  hitOvfFlag;
    logic                  addrMapped;
    logic [7:0]            wrByte;
    logic [31:0]           readValue;

    // Flag set and clear terms.
    logic [CHAN_COUNT-1:0] chanSet;
    logic [CHAN_COUNT-1:0] chanClear;
    logic                  ovfSet;
    logic                  ovfClear;
    logic                  rollover;

    // Views of the registers as 8-bit images.
    logic [7:0]            sysCtrlImage;
    logic [7:0]            chanIenImage;
    logic [7:0]            cntCtrlImage;
    logic [7:0]            chanFlagImage;
    logic [7:0]            ovfFlagImage;

    // Prescaler link.
    tip_presc_if #(.SEL_W(DIV_SEL_W)) prescLink ();

    tip_prescaler #(
        .SEL_W (DIV_SEL_W)
    ) u_prescaler (
        .clk   (clk),
        .rst_n (rst_n),
        .pif   (prescLink.presc)
    );

    // The ratio request goes straight to the prescaler, which decides when it lands.
    assign prescLink.divSel = divSel_reg;
    assign prescaleTick     = prescLink.tick;

    // APB phases: the slave never inserts wait states.
    assign setupPhase  = psel & ~penable;
    assign accessPhase = psel & penable;
    assign pready      = 1'b1;
    assign wrStrobe    = accessPhase & pwrite & pready;
    assign wrByte      = pwdata[7:0];

    // Address decode on the full byte address; unaligned addresses miss.
    assign hitSysCtrl  = (paddr == SYS_CTRL_OFFS);
    assign hitChanIen  = (paddr == CHAN_IEN_OFFS);
    assign hitCntCtrl  = (paddr == CNT_CTRL_OFFS);
    assign hitChanFlag = (paddr == CHAN_FLAG_OFFS);
    assign hitOvfFlag  = (paddr == OVF_FLAG_OFFS);
    assign addrMapped  = hitSysCtrl | hitChanIen | hitCntCtrl | hitChanFlag | hitOvfFlag;

    // An unmapped address is answered with an error and has no effect.
    assign pslverr = accessPhase & ~addrMapped;

    // Register images; reserved bits read as zero.
    always_comb begin
        sysCtrlImage                             = 8'h00;
        sysCtrlImage[FAST_CLEAR_BIT]             = fastClearEn_reg;
        chanIenImage                             = 8'h00;
        chanIenImage[CHAN_LSB +: CHAN_COUNT]     = chanIrqEn_reg;
        cntCtrlImage                             = 8'h00;
        cntCtrlImage[OVF_IRQ_EN_BIT]             = ovfIrqEn_reg;
        cntCtrlImage[CMP7_CLEAR_BIT]             = cmp7ClearEn_reg;
        cntCtrlImage[DIV_SEL_LSB +: DIV_SEL_W]   = divSel_reg;
        chanFlagImage                            = 8'h00;
        chanFlagImage[CHAN_LSB +: CHAN_COUNT]    = chanFlag_reg;
        ovfFlagImage                             = 8'h00;
        ovfFlagImage[OVF_FLAG_BIT]               = ovfFlag_reg;
    end

    // Read multiplexer; data sits in the low byte, upper bits read as zero.
    always_comb begin
        readValue = 32'h0000_0000;
        if (hitSysCtrl) begin
            readValue[7:0] = sysCtrlImage;
        end else if (hitChanIen) begin
            readValue[7:0] = chanIenImage;
        end else if (hitCntCtrl) begin
            readValue[7:0] = cntCtrlImage;
        end else if (hitChanFlag) begin
            readValue[7:0] = chanFlagImage;
        end else if (hitOvfFlag) begin
            readValue[7:0] = ovfFlagImage;
        end
    end

    // Read data is captured in the setup cycle so prdata comes from a flip-flop.
    // A flag that sets during the access cycle shows on the next read.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setupPhase & ~pwrite) begin
            prdata_reg <= readValue;
        end
    end

    assign prdata = prdata_reg;

    // System control: only the fast clear enable is held here.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fastClearEn_reg <= SYS_CTRL_RST[FAST_CLEAR_BIT];
        end else if (wrStrobe & hitSysCtrl) begin
            fastClearEn_reg <= wrByte[FAST_CLEAR_BIT] & SYS_CTRL_MASK[FAST_CLEAR_BIT];
        end
    end

    assign fastClearActive = fastClearEn_reg;

    // Channel interrupt enables, one per channel in the flag bit positions.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chanIrqEn_reg <= CHAN_IEN_RST[CHAN_LSB +: CHAN_COUNT];
        end else if (wrStrobe & hitChanIen) begin
            chanIrqEn_reg <= wrByte[CHAN_LSB +: CHAN_COUNT] &
                             CHAN_IEN_MASK[CHAN_LSB +: CHAN_COUNT];
        end
    end

    // Counter control: overflow enable, clear on compare 7, divider select.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovfIrqEn_reg    <= CNT_CTRL_RST[OVF_IRQ_EN_BIT];
            cmp7ClearEn_reg <= CNT_CTRL_RST[CMP7_CLEAR_BIT];
            divSel_reg      <= DIV_SEL_RST;
        end else if (wrStrobe & hitCntCtrl) begin
            ovfIrqEn_reg    <= wrByte[OVF_IRQ_EN_BIT] & CNT_CTRL_MASK[OVF_IRQ_EN_BIT];
            cmp7ClearEn_reg <= wrByte[CMP7_CLEAR_BIT] & CNT_CTRL_MASK[CMP7_CLEAR_BIT];
            divSel_reg      <= wrByte[DIV_SEL_LSB +: DIV_SEL_W];
        end
    end

    // Counter clear request. A compare-7 match resets the counter; with the
    // compare value at zero the request stays up, so the counter sits at zero.
    // With the enable off the counter is left to free-run.
    assign counterClear = cmp7ClearEn_reg & (compare7Match | compare7IsZero);

    // A rollover is the counter stepping past its maximum on a tick. When the
    // same step is a compare-driven reset it is not an overflow, which keeps
    // a maximum compare value from flagging on every period.
    assign rollover = prescaleTick & counterAtMax;
    assign ovfSet   = rollover & ~counterClear;

    // Channel flag set and clear terms. Fast clear follows the engine's
    // strobes, which already tell capture reads from compare writes.
    assign chanSet   = chanEventStrobe;
    assign chanClear = ((wrStrobe & hitChanFlag) ?
                        wrByte[CHAN_LSB +: CHAN_COUNT] : {CHAN_COUNT{1'b0}}) |
                       ({CHAN_COUNT{fastClearEn_reg}} &
                        (captureReadStrobe | compareWriteStrobe));

    // Overflow clear by a write with bit 7 set, or by any counter access
    // while fast clear is on.
    assign ovfClear = (wrStrobe & hitOvfFlag & wrByte[OVF_FLAG_BIT]) |
                      (fastClearEn_reg & counterAccessStrobe);

    // Next flag values; a set in the clearing cycle survives the clear.
    always_comb begin
        chanFlag_next = (chanFlag_reg & ~chanClear) | chanSet;
        ovfFlag_next  = (ovfFlag_reg & ~ovfClear) | ovfSet;
    end

    // Channel flags; bits written with zero keep their state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chanFlag_reg <= CHAN_FLAG_RST[CHAN_LSB +: CHAN_COUNT];
        end else begin
            chanFlag_reg <= chanFlag_next;
        end
    end

    // Overflow flag.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovfFlag_reg <= OVF_FLAG_RST[OVF_FLAG_BIT];
        end else begin
            ovfFlag_reg <= ovfFlag_next;
        end
    end

    // Interrupt requests are plain gates of registered flags and enables,
    // so they fall in the cycle after the flag is cleared.
    assign chanIrqReq = chanFlag_reg & chanIrqEn_reg;
    assign ovfIrqReq  = ovfFlag_reg & ovfIrqEn_reg;
    assign irq        = (|chanIrqReq) | ovfIrqReq;

endmodule

// ===== tip_timer_ctrl_sva.sv
// Port-level checker for the timer control slice.
// Assumes single bus clock, rst_n async low, zero-wait APB.
`timescale 1ns/1ps
module tip_timer_ctrl_sva
    import tip_pkg::*;
(
    // Clock, reset and APB request.
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // Strobes and status from the engines.
    input wire logic [3:0]  chanEventStrobe,
    input wire logic [3:0]  captureReadStrobe,
    input wire logic [3:0]  compareWriteStrobe,
    input wire logic        counterAccessStrobe,
    input wire logic        counterAtMax,
    input wire logic        compare7Match,
    input wire logic        compare7IsZero,
    // Outputs under watch.
    input wire logic        prescaleTick,
    input wire logic        counterClear,
    input wire logic        fastClearActive,
    input wire logic [3:0]  chanIrqReq,
    input wire logic        ovfIrqReq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Register writes at the taking edge and a real rollover, used as causes below.
    logic wrAcc;
    logic ovfEvt;
    assign wrAcc = psel && penable && pwrite;
    assign ovfEvt = prescaleTick && counterAtMax && !counterClear;
    // Requests may only rise for the causes listed, and must clear or follow the writes and strobes that require it.
    a_clear_cause: assert property (counterClear |-> compare7Match || compare7IsZero)
        else $error("counter clear without a compare cause");
    a_zero_holds: assert property (counterClear && compare7IsZero
        && !(wrAcc && paddr == CNT_CTRL_OFFS) |=> !compare7IsZero || counterClear)
        else $error("counter not held at zero");
    a_chan_rise: assert property ((chanIrqReq & ~$past(chanIrqReq) & ~$past(chanEventStrobe))
        == 4'h0 || $past(wrAcc && paddr == CHAN_IEN_OFFS))
        else $error("channel request rose without event");
    a_chan_w1c: assert property (wrAcc && paddr == CHAN_FLAG_OFFS
        |=> (chanIrqReq & $past(pwdata[7:4] & ~chanEventStrobe)) == 4'h0)
        else $error("channel flag not cleared by one");
    a_ovf_rise: assert property ($rose(ovfIrqReq)
        |-> $past(ovfEvt) || $past(wrAcc && paddr == CNT_CTRL_OFFS))
        else $error("overflow request without rollover");
    a_ovf_w1c: assert property (wrAcc && paddr == OVF_FLAG_OFFS && pwdata[7] && !ovfEvt
        |=> !ovfIrqReq)
        else $error("overflow flag not cleared");
    a_fast_ovf: assert property (fastClearActive && counterAccessStrobe && !ovfEvt
        |=> !ovfIrqReq)
        else $error("counter access left overflow set");
    a_fast_chan: assert property (fastClearActive |=> (chanIrqReq
        & $past((captureReadStrobe | compareWriteStrobe) & ~chanEventStrobe)) == 4'h0)
        else $error("fast clear left channel flag set");
    a_fast_bit: assert property (wrAcc && paddr == SYS_CTRL_OFFS
        |=> fastClearActive == $past(pwdata[4]))
        else $error("fast clear enable not taken");
    // Main scenarios reached.
    c_ovf: cover property (ovfEvt ##1 ovfIrqReq);
    c_mod: cover property (counterClear && counterAtMax && prescaleTick);
    c_fast: cover property (fastClearActive && counterAccessStrobe);
endmodule

bind tip_timer_ctrl tip_timer_ctrl_sva u_sva (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .chanEventStrobe(chanEventStrobe), .captureReadStrobe(captureReadStrobe),
    .compareWriteStrobe(compareWriteStrobe), .counterAccessStrobe(counterAccessStrobe),
    .counterAtMax(counterAtMax), .compare7Match(compare7Match),
    .compare7IsZero(compare7IsZero), .prescaleTick(prescaleTick),
    .counterClear(counterClear), .fastClearActive(fastClearActive),
    .chanIrqReq(chanIrqReq), .ovfIrqReq(ovfIrqReq));

// ===== tb_top.sv
// Self-checking bench for the timer control slice: APB master and strobes.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/1ps
module tb_top
    import tip_pkg::*;
;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic        pready, pslverr, prescaleTick, counterClear, fastClearActive, ovfIrqReq, irq;
    logic [3:0]  chanEventStrobe = '0, captureReadStrobe = '0, compareWriteStrobe = '0;
    logic [3:0]  chanIrqReq;
    logic        counterAccessStrobe = 0, counterAtMax = 0, compare7Match = 0;
    logic        compare7IsZero = 0, clrSeen;
    int          miscompares = 0, comparisons = 0, cyc = 0;

    // Bus clock and a cycle count for tick spacing.
    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    tip_timer_ctrl u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chanEventStrobe(chanEventStrobe),
        .captureReadStrobe(captureReadStrobe), .compareWriteStrobe(compareWriteStrobe),
        .counterAccessStrobe(counterAccessStrobe), .counterAtMax(counterAtMax),
        .compare7Match(compare7Match), .compare7IsZero(compare7IsZero),
        .prescaleTick(prescaleTick), .counterClear(counterClear),
        .fastClearActive(fastClearActive), .chanIrqReq(chanIrqReq),
        .ovfIrqReq(ovfIrqReq), .irq(irq));

    task automatic wrap_up();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    // One APB transfer; waits for pready without assuming a latency.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, '0, r, e);
        chk("prdata", x, r);
        chk("pslverr", xe, e);
    endtask

    // One-cycle pulse on the engine strobes; counterClear is caught mid-pulse.
    task automatic ev(input logic [3:0] s, c, w, input logic a, m, t);
        @(posedge clk);
        {chanEventStrobe, captureReadStrobe, compareWriteStrobe} <= {s, c, w};
        {counterAccessStrobe, counterAtMax, compare7Match} <= {a, m, t};
        #1 clrSeen = counterClear;
        @(posedge clk);
        {chanEventStrobe, captureReadStrobe, compareWriteStrobe} <= '0;
        {counterAccessStrobe, counterAtMax, compare7Match} <= '0;
        #1;
    endtask

    task automatic nextTick(output int t);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (prescaleTick !== 1'b1 && n < 300);
        if (prescaleTick !== 1'b1) begin
            miscompares++;
            wrap_up();
        end
        t = cyc;
    endtask

    task automatic t_regs();
        logic [7:0] ad [5] = '{SYS_CTRL_OFFS, CHAN_IEN_OFFS, CNT_CTRL_OFFS,
                               CHAN_FLAG_OFFS, OVF_FLAG_OFFS};
        logic [7:0] mk [3] = '{8'h10, 8'hf0, 8'h8f};
        int t;
        chk("irq", 0, irq);
        for (int i = 0; i < 5; i++) rd(ad[i], 0, 0);
        for (int i = 0; i < 3; i++) begin
            wr(ad[i], 32'hffff_ffff);
            rd(ad[i], mk[i], 0);
            wr(ad[i], 0);
        end
        // Divide-by-128 stays active until its period ends; later rollovers need ticks.
        nextTick(t);
        rd(8'h14, 0, 1);
    endtask

    task automatic t_chan();
        wr(CHAN_IEN_OFFS, 32'hf0);
        for (int i = 0; i < 4; i++) begin
            ev(4'h1 << i, '0, '0, '0, '0, '0);
            chk("chanIrqReq", 4'h1 << i, chanIrqReq);
            chk("irq", 1, irq);
            wr(CHAN_FLAG_OFFS, 32'h0f);
            rd(CHAN_FLAG_OFFS, 32'h10 << i, 0);
            wr(CHAN_FLAG_OFFS, 32'h10 << i);
            chk("irq", 0, irq);
        end
        wr(CHAN_IEN_OFFS, 0);
        ev(4'hf, '0, '0, '0, '0, '0);
        chk("chanIrqReq", 0, chanIrqReq);
        rd(CHAN_FLAG_OFFS, 32'hf0, 0);
        wr(CHAN_IEN_OFFS, 32'ha0);
        chk("chanIrqReq", 4'ha, chanIrqReq);
        // Event on channel 4 lands on the same edge as its clear.
        fork
            wr(CHAN_FLAG_OFFS, 32'hf0);
            begin
                repeat (2) @(posedge clk);
                chanEventStrobe <= 4'h1;
                @(posedge clk);
                chanEventStrobe <= '0;
            end
        join
        rd(CHAN_FLAG_OFFS, 32'h10, 0);
        wr(CHAN_FLAG_OFFS, 32'h10);
    endtask

    task automatic t_ovf();
        wr(CNT_CTRL_OFFS, 32'h80);
        ev('0, '0, '0, '0, 1'b1, '0);
        chk("ovfIrqReq", 1, ovfIrqReq);
        chk("irq", 1, irq);
        wr(OVF_FLAG_OFFS, 32'h7f);
        rd(OVF_FLAG_OFFS, 32'h80, 0);
        wr(OVF_FLAG_OFFS, 32'h80);
        chk("ovfIrqReq", 0, ovfIrqReq);
        wr(CNT_CTRL_OFFS, 32'h08);
        ev('0, '0, '0, '0, 1'b1, '0);
        chk("ovfIrqReq", 0, ovfIrqReq);
        rd(OVF_FLAG_OFFS, 32'h80, 0);
        wr(OVF_FLAG_OFFS, 32'h80);
        ev('0, '0, '0, '0, 1'b1, 1'b1);
        chk("counterClear", 1, clrSeen);
        rd(OVF_FLAG_OFFS, 0, 0);
        @(posedge clk);
        compare7IsZero <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk("counterClear", 1, counterClear);
        wr(CNT_CTRL_OFFS, 0);
        chk("counterClear", 0, counterClear);
        @(posedge clk);
        compare7IsZero <= 1'b0;
        ev('0, '0, '0, '0, '0, 1'b1);
        chk("counterClear", 0, clrSeen);
    endtask

    task automatic t_fast();
        wr(SYS_CTRL_OFFS, 32'h10);
        chk("fastClearActive", 1, fastClearActive);
        ev(4'hf, '0, '0, '0, 1'b1, '0);
        ev('0, 4'h1, 4'h2, '0, '0, '0);
        rd(CHAN_FLAG_OFFS, 32'hc0, 0);
        ev('0, 4'h4, 4'h8, 1'b1, '0, '0);
        rd(CHAN_FLAG_OFFS, 0, 0);
        rd(OVF_FLAG_OFFS, 0, 0);
        wr(SYS_CTRL_OFFS, 0);
        ev(4'hf, '0, '0, '0, 1'b1, '0);
        ev('0, 4'hf, 4'hf, 1'b1, '0, '0);
        rd(CHAN_FLAG_OFFS, 32'hf0, 0);
        rd(OVF_FLAG_OFFS, 32'h80, 0);
        wr(CHAN_FLAG_OFFS, 32'hf0);
        wr(OVF_FLAG_OFFS, 32'h80);
    endtask

    // Each new ratio is written after a tick; for old ratios of 8 and up the old spacing must finish first.
    task automatic t_presc();
        int s, t0, t1, t2, t3;
        for (int k = 1; k <= 8; k++) begin
            s = k % 8;
            nextTick(t0);
            wr(CNT_CTRL_OFFS, s);
            nextTick(t1);
            nextTick(t2);
            nextTick(t3);
            if (k > 3) chk("old spacing", 1 << (k - 1), t1 - t0);
            chk("tick spacing", 1 << s, t3 - t2);
        end
    endtask

    // Main sequence.
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_chan();
        t_ovf();
        t_fast();
        t_presc();
        wrap_up();
    end
endmodule
